// [logic/asr_buffer.sv]
// Two-entry buffer for finished result words, valid/ready on both sides.
// Assumes one clock and that the writer pushes only while in_ready is high.
`timescale 1ns/10ps
`default_nettype none

module asr_buffer
  import asr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        in_valid,
  input  wire logic [15:0] in_data,
  output logic             in_ready,
  output logic             out_valid,
  output logic [15:0]      out_data,
  input  wire logic        out_ready
);

  logic [15:0] slot [2];
  logic [1:0]  slot_valid;
  logic [15:0] next_slot [2];
  logic [1:0]  next_slot_valid;
  logic        pop;
  logic        push;

  // Slot 0 is the head and drives the outputs straight from its flops.
  always_comb begin
    pop             = slot_valid[0] & out_ready;
    push            = in_valid & ~slot_valid[1];
    next_slot[0]    = slot[0];
    next_slot[1]    = slot[1];
    next_slot_valid = slot_valid;
    if (pop) begin
      if (slot_valid[1]) begin
        next_slot[0]       = slot[1];
        next_slot_valid[1] = push;
        next_slot[1]       = in_data;
      end else begin
        next_slot_valid[0] = push;
        next_slot[0]       = in_data;
      end
    end else if (push) begin
      if (!slot_valid[0]) begin
        next_slot_valid[0] = 1'b1;
        next_slot[0]       = in_data;
      end else begin
        next_slot_valid[1] = 1'b1;
        next_slot[1]       = in_data;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      slot[0]    <= WORD_RESET;
      slot[1]    <= WORD_RESET;
      slot_valid <= 2'h0;
    end else begin
      slot[0]    <= next_slot[0];
      slot[1]    <= next_slot[1];
      slot_valid <= next_slot_valid;
    end
  end

  assign in_ready  = ~slot_valid[1];
  assign out_valid = slot_valid[0];
  assign out_data  = slot[0];

endmodule

`default_nettype wire

// [logic/asr_pkg.sv]
// Constants and types shared by the serial converter readout block.
// Assumes a single clock domain; the package holds no logic of its own.
package asr_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_BITS  = 16;
  localparam int unsigned CODE_BITS  = 12;
  localparam int unsigned LEAD_ZEROS = 4;
  localparam logic [4:0]  LEAD_ZEROS_5   = 5'h04;
  localparam logic [4:0]  LAST_BIT_INDEX = 5'h0F;
  localparam logic [4:0]  WORD_BITS_5    = 5'h10;
  localparam logic [3:0]  LEAD_FILL      = 4'h0;

  // ----------------------------------------------------------------
  // Resolution variants and their converted bit counts
  // ----------------------------------------------------------------
  localparam logic [1:0]  RES_SEL_12 = 2'h0;
  localparam logic [1:0]  RES_SEL_10 = 2'h1;
  localparam logic [1:0]  RES_SEL_8  = 2'h2;
  localparam logic [4:0]  RES_BITS_12 = 5'h0C;
  localparam logic [4:0]  RES_BITS_10 = 5'h0A;
  localparam logic [4:0]  RES_BITS_8  = 5'h08;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [1:0]  RES_SEL_RESET = RES_SEL_12;

  typedef enum logic [1:0] {
    ASR_IDLE,
    ASR_FRAME,
    ASR_REFUSED
  } asr_state_t;

endpackage

// [logic/asr_readout.sv]
// Conversion control and serial result readout of a successive
// approximation converter, 12-, 10- or 8-bit variant.
// Assumes select and serial clock are synchronous to mclk and much slower,
// and that an analog comparator answers the trial code on cmp_above.
// The host must keep each serial clock level for at least one mclk
// cycle; shorter pulses can be missed and the word comes out short.
//
// Summary of operation
// - Select input is active low.
// - Select falling starts conversion and opens frame; a full buffer refuses it.
// - Result bits change on serial clock falling edges.
// - 12-bit: four zeros, twelve bits, MSB first.
// - 10-bit: four zeros, ten bits, two zeros.
// - 8-bit: four zeros, eight bits, four zeros.
// - Serial clock alone paces the conversion.
// - Return to tracking when conversion ends.
// - Result is straight unsigned binary.
// - One 16-bit word per conversion.
`timescale 1ns/10ps
`default_nettype none

module asr_readout
  import asr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        conv_select_n,
  input  wire logic        serial_clk,
  input  wire logic [1:0]  resolution_sel,
  input  wire logic        cmp_above,
  output logic             serial_result_out,
  output logic             serial_result_oe_n,
  output logic             track_hold,
  output logic [11:0]      dac_code,
  output logic             conv_busy,
  output logic             result_valid,
  output logic [15:0]      result_data,
  input  wire logic        result_ready
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // A strap value of three has no variant of its own and falls back to
  // the widest one, so an unstrapped part still gives a usable word.
  function automatic logic [4:0] res_bits(input logic [1:0] sel);
    case (sel)
      RES_SEL_10: res_bits = RES_BITS_10;
      RES_SEL_8:  res_bits = RES_BITS_8;
      default:    res_bits = RES_BITS_12;
    endcase
  endfunction

  // True when word position idx carries a converted bit.
  // Positions count from zero at the first leading zero.
  function automatic logic is_code_pos(input logic [4:0] idx,
                                       input logic [4:0] nbits);
    is_code_pos = (idx >= LEAD_ZEROS_5) && (idx < LEAD_ZEROS_5 + nbits);
  endfunction

  // ----------------------------------------------------------------
  // Resolution strap
  // ----------------------------------------------------------------
  // The strap is caught on the first edge after reset release, since an
  // asynchronous reset may only load constants.
  logic [1:0] res_sel;
  logic       strap_taken;
  logic [1:0] next_res_sel;
  logic       next_strap_taken;

  always_comb begin
    next_res_sel     = res_sel;
    next_strap_taken = 1'b1;
    if (!strap_taken) begin
      next_res_sel = resolution_sel;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      res_sel     <= RES_SEL_RESET;
      strap_taken <= 1'b0;
    end else begin
      res_sel     <= next_res_sel;
      strap_taken <= next_strap_taken;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection on the host pins
  // ----------------------------------------------------------------
  // Both history flops reset to the idle high level of their pins.
  // With this reset a select or serial clock held low through reset is seen
  // as a fall on the first edge after release; only a high pin stays quiet.
  logic select_q;
  logic sclk_q;
  logic select_fall;
  logic select_high;
  logic sclk_fall;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      select_q <= 1'b1;
      sclk_q   <= 1'b1;
    end else begin
      select_q <= conv_select_n;
      sclk_q   <= serial_clk;
    end
  end

  always_comb begin
    select_fall = select_q & ~conv_select_n;
    select_high = conv_select_n;
    sclk_fall = sclk_q & ~serial_clk;
  end

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  // The buffer decouples the word consumer from the host's framing. Two
  // entries let one word wait while the next conversion runs; a third
  // frame is refused rather than overwriting a word nobody has taken.
  logic        push_valid;
  logic [15:0] push_data;
  logic        buf_ready;

  asr_buffer u_buffer (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (push_valid),
    .in_data   (push_data),
    .in_ready  (buf_ready),
    .out_valid (result_valid),
    .out_data  (result_data),
    .out_ready (result_ready)
  );

  // ----------------------------------------------------------------
  // Conversion and frame sequencer
  // ----------------------------------------------------------------
  // One frame, counted in serial clock falls after select goes low:
  //   select fall  drive the line, leading zero, enter hold
  //   falls 1..3   remaining leading zeros; fall 3 raises the first trial
  //   falls 4..    one decision per fall, shown on the line at once
  //   fall 3+N     last decision, word to the buffer, back to track
  //   later falls  trailing zeros until sixteen bits have gone out
  // Showing each decision on the fall that makes it keeps the word free
  // of pipeline delay, at the cost of a comparator that must settle
  // within one serial clock period of the trial code changing.

  asr_state_t  state;
  logic [4:0]  bit_cnt;
  logic [11:0] code;
  logic        sdo;
  logic        sdo_oe_n;
  logic        hold;
  logic        busy;
  asr_state_t  next_state;
  logic [4:0]  next_bit_cnt;
  logic [11:0] next_code;
  logic        next_sdo;
  logic        next_sdo_oe_n;
  logic        next_hold;
  logic        next_busy;
  logic        next_push_valid;
  logic [15:0] next_push_data;
  logic [4:0]  nbits;
  logic [4:0]  idx;
  logic [4:0]  dec_pos;
  logic [4:0]  trial_pos;

  always_comb begin
    nbits           = res_bits(res_sel);
    idx             = bit_cnt + 5'h01;
    dec_pos         = LAST_BIT_INDEX - idx;
    trial_pos       = dec_pos - 5'h01;
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_code       = code;
    next_sdo        = sdo;
    next_sdo_oe_n   = sdo_oe_n;
    next_hold       = hold;
    next_busy       = busy;
    next_push_valid = 1'b0;
    next_push_data  = push_data;
    case (state)
      ASR_IDLE: begin
        if (select_fall) begin
          // A full buffer refuses the frame so that no result is lost.
          if (buf_ready) begin
            next_state    = ASR_FRAME;
            next_bit_cnt  = 5'h00;
            next_code     = CODE_RESET;
            next_hold     = 1'b1;
            next_busy     = 1'b1;
            next_sdo_oe_n = 1'b0;
            next_sdo      = 1'b0;
          end else begin
            next_state = ASR_REFUSED;
          end
        end
      end
      ASR_FRAME: begin
        if (select_high) begin
          next_state    = ASR_IDLE;
          next_sdo_oe_n = 1'b1;
          next_sdo      = 1'b0;
          // An aborted word is dropped and never reaches the buffer.
          // aborted conversion tracks again
          next_hold     = 1'b0;
          next_busy     = 1'b0;
          next_code     = CODE_RESET;
        end else if (sclk_fall && bit_cnt < WORD_BITS_5) begin
          next_bit_cnt = idx;
          next_sdo     = 1'b0;
          if (idx <= LAST_BIT_INDEX && is_code_pos(idx, nbits)) begin
            // keep trial bit when input at or above it
            next_code[dec_pos[3:0]] = cmp_above;
            next_sdo                = cmp_above;
          end
          if (is_code_pos(idx + 5'h01, nbits)) begin
            next_code[trial_pos[3:0]] = 1'b1;
          end
          if (idx == LEAD_ZEROS_5 + nbits - 5'h01) begin
            next_hold       = 1'b0;
            next_busy       = 1'b0;
            // unused low code bits stay zero
            next_push_valid = 1'b1;
            next_push_data  = {LEAD_FILL, next_code};
          end
        end
      end
      ASR_REFUSED: begin
        // The line stays released, so a host that ignores the refusal
        // reads an undriven line rather than a stale word.
        // host releases select before the next start
        if (select_high) begin
          next_state = ASR_IDLE;
        end
      end
      default: begin
        next_state    = ASR_IDLE;
        next_sdo_oe_n = 1'b1;
        next_hold     = 1'b0;
        next_busy     = 1'b0;
      end
    endcase
    // The first trial bit goes up one edge before its decision.
    if (state == ASR_FRAME && !select_high && sclk_fall &&
        idx == LEAD_ZEROS_5 - 5'h01) begin
      next_code[CODE_BITS - 1] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= ASR_IDLE;
      bit_cnt    <= 5'h00;
      code       <= CODE_RESET;
      sdo        <= 1'b0;
      sdo_oe_n   <= 1'b1;
      hold       <= 1'b0;
      busy       <= 1'b0;
      push_valid <= 1'b0;
      push_data  <= WORD_RESET;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      code       <= next_code;
      sdo        <= next_sdo;
      sdo_oe_n   <= next_sdo_oe_n;
      hold       <= next_hold;
      busy       <= next_busy;
      push_valid <= next_push_valid;
      push_data  <= next_push_data;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a plain copy of a register, so the host sees no
  // combinational path from its own pins back to the line.
  assign serial_result_out  = sdo;
  assign serial_result_oe_n = sdo_oe_n;
  assign track_hold         = hold;
  assign dac_code           = code;
  assign conv_busy          = busy;

endmodule

`default_nettype wire

// [test/asr_host_model.sv]
// Host model: frames a conversion, clocks out the word, models the input.
// Assumes it is driven from the bench on falling mclk edges.
`timescale 1ns/10ps
`default_nettype none

module asr_host_model
  import asr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic [11:0] dac_code,
  input  wire logic        serial_result_out,
  input  wire logic        serial_result_oe_n,
  output logic             conv_select_n,
  output logic             serial_clk,
  output logic             cmp_above
);
  logic [11:0] level;
  int          half;

  // --------------------------------------------------------------
  // Analog side and serial framing
  // --------------------------------------------------------------
  assign cmp_above = level >= dac_code;

  initial begin
    conv_select_n = 1'b1;
    serial_clk    = 1'b1;
    level         = 12'h000;
    half          = 2;
  end

  // A released line reads as the inverse of the last bit, never a copy.
  task automatic frame(input int n, output logic [15:0] w, output logic drv);
    @(negedge mclk);
    conv_select_n = 1'b0;
    repeat (half) @(negedge mclk);
    drv = !serial_result_oe_n;
    w = 16'h0000;
    for (int k = 0; k < n; k++) begin
      w = {w[14:0], serial_result_oe_n ? ~w[0] : serial_result_out};
      serial_clk = 1'b0;
      repeat (half) @(negedge mclk);
      serial_clk = 1'b1;
      repeat (half) @(negedge mclk);
    end
    conv_select_n = 1'b1;
    repeat (half) @(negedge mclk);
  endtask
endmodule

`default_nettype wire

// [test/asr_readout_chk.sv]
// Port checker for asr_readout, attached by the bind at the foot.
// Assumes the resolution strap only changes while reset is low.
`timescale 1ns/10ps
`default_nettype none

module asr_readout_chk
  import asr_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        conv_select_n,
  input wire logic        serial_clk,
  input wire logic [1:0]  resolution_sel,
  input wire logic        serial_result_out,
  input wire logic        serial_result_oe_n,
  input wire logic        track_hold,
  input wire logic        conv_busy,
  input wire logic        result_valid,
  input wire logic [15:0] result_data,
  input wire logic        result_ready
);
  logic       sclk_q;
  logic [4:0] cnt;
  logic [4:0] nb;
  logic [3:0] tm;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  assign nb = (resolution_sel == RES_SEL_10) ? RES_BITS_10 :
              (resolution_sel == RES_SEL_8) ? RES_BITS_8 : RES_BITS_12;
  assign tm = (resolution_sel == RES_SEL_10) ? 4'h3 :
              (resolution_sel == RES_SEL_8) ? 4'hF : 4'h0;

  // The fall count equals the index of the bit shown on the line.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b1;
      cnt    <= 5'h00;
    end else begin
      sclk_q <= serial_clk;
      cnt    <= conv_select_n ? 5'h00 : cnt + {4'h0, sclk_q & ~serial_clk};
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  oe_release_a: assert property (
    conv_select_n [*3] |-> serial_result_oe_n && !serial_result_out)
    else $error("output not released while deselected");
  frame_start_a: assert property (
    $fell(conv_select_n) && !result_valid |->
    ##[1:2] (!serial_result_oe_n && track_hold && conv_busy))
    else $error("select fall did not open a frame");
  bit_edge_a: assert property (
    $changed(serial_result_out) |->
    ($past(serial_clk, 2) && !$past(serial_clk)) || $past(conv_select_n))
    else $error("output bit moved without a clock fall");
  lead_zero_a: assert property (
    !serial_result_oe_n && cnt < 5'h04 |-> !serial_result_out)
    else $error("leading bit not zero");
  trail_zero_a: assert property (
    !serial_result_oe_n && cnt >= 5'h04 + nb |-> !serial_result_out)
    else $error("trailing bit not zero");
  hold_end_a: assert property (
    $fell(track_hold) |-> $past(conv_select_n) || cnt == 5'h03 + nb)
    else $error("tracking resumed at the wrong bit");
  track_done_a: assert property (
    !serial_result_oe_n && cnt == 5'h04 + nb |-> !track_hold)
    else $error("still holding after the last bit");
  word_form_a: assert property (
    result_valid |-> result_data[15:12] == LEAD_FILL &&
    (result_data[3:0] & tm) == 4'h0)
    else $error("result word padding wrong");
  word_stand_a: assert property (
    result_valid && !result_ready |=> result_valid && $stable(result_data))
    else $error("result word changed before taken");
  word_late_a: assert property (
    $fell(conv_busy) && !$past(conv_select_n) && !result_valid |->
    ##[1:3] result_valid)
    else $error("finished word not offered");

  done_c: cover property ($fell(track_hold) && !$past(conv_select_n));
  refuse_c: cover property ($fell(conv_select_n) ##3 serial_result_oe_n);
  pops_c: cover property (result_valid && result_ready ##1 result_valid);
endmodule

bind asr_readout asr_readout_chk i_asr_readout_chk (
  .mclk, .reset_n, .conv_select_n, .serial_clk, .resolution_sel,
  .serial_result_out, .serial_result_oe_n, .track_hold, .conv_busy,
  .result_valid, .result_data, .result_ready
);

`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for asr_readout driven by the host model.
// Assumes the checker is bound in; the strap changes only in reset.
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import asr_pkg::*;
();
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [1:0]  resolution_sel = 2'h0;
  logic        result_ready = 1'b0;
  logic        conv_select_n, serial_clk, cmp_above, serial_result_out;
  logic        serial_result_oe_n, track_hold, conv_busy, result_valid;
  logic [11:0] dac_code;
  logic [15:0] result_data, w;
  logic        drv;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  asr_readout i_asr_readout (
    .mclk, .reset_n, .conv_select_n, .serial_clk, .resolution_sel,
    .cmp_above, .serial_result_out, .serial_result_oe_n, .track_hold,
    .dac_code, .conv_busy, .result_valid, .result_data, .result_ready
  );
  asr_host_model i_asr_host_model (
    .mclk, .dac_code, .serial_result_out, .serial_result_oe_n,
    .conv_select_n, .serial_clk, .cmp_above
  );

  // --------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // --------------------------------------------------------------
  always #2.5 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [15:0] expw(input logic [1:0] s,
                                       input logic [11:0] v);
    case (s)
      RES_SEL_10: return {4'h0, v[11:2], 2'h0};
      RES_SEL_8:  return {4'h0, v[11:4], 4'h0};
      default:    return {4'h0, v};
    endcase
  endfunction

  task automatic do_reset(input logic [1:0] sel);
    @(negedge mclk);
    reset_n = 1'b0;
    resolution_sel = sel;
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    repeat (2) @(negedge mclk);
  endtask

  task automatic pop(input logic [15:0] exp);
    for (int i = 0; i < 20 && result_valid !== 1'b1; i++) @(negedge mclk);
    check("result valid", {15'h0, result_valid}, 16'h0001);
    check("result word", result_data, exp);
    result_ready = 1'b1;
    @(negedge mclk);
    result_ready = 1'b0;
  endtask

  task automatic run_word(input logic [11:0] lv, input logic [15:0] exp);
    i_asr_host_model.level = lv;
    i_asr_host_model.frame(16, w, drv);
    check("driven", {15'h0, drv}, 16'h0001);
    check("serial word", w, exp);
    pop(exp);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_variants();
    logic [11:0] lv [3] = '{12'hFFF, 12'h000, 12'hA5C};
    for (int s = 0; s < 4; s++) begin
      do_reset(2'(s));
      foreach (lv[i]) run_word(lv[i], expw(2'(s), lv[i]));
    end
    $display("variants test done");
  endtask

  task automatic t_full();
    do_reset(RES_SEL_12);
    i_asr_host_model.half = 5;
    i_asr_host_model.level = 12'h123;
    i_asr_host_model.frame(16, w, drv);
    i_asr_host_model.level = 12'h800;
    i_asr_host_model.frame(16, w, drv);
    check("second word", w, 16'h0800);
    i_asr_host_model.frame(16, w, drv);
    check("refused drive", {15'h0, drv}, 16'h0000);
    check("head word", result_data, 16'h0123);
    result_ready = 1'b1;
    @(negedge mclk);
    check("next word", result_data, 16'h0800);
    @(negedge mclk);
    result_ready = 1'b0;
    check("drained", {15'h0, result_valid}, 16'h0000);
    i_asr_host_model.half = 2;
    run_word(12'h5A3, 16'h05A3);
    $display("full buffer test done");
  endtask

  task automatic t_abort();
    i_asr_host_model.level = 12'hC3C;
    i_asr_host_model.frame(6, w, drv);
    check("partial bits", w, 16'h0003);
    repeat (10) @(negedge mclk);
    check("abort word", {15'h0, result_valid}, 16'h0000);
    check("abort track", {15'h0, track_hold}, 16'h0000);
    check("idle enable", {15'h0, serial_result_oe_n}, 16'h0001);
    run_word(12'h3C7, 16'h03C7);
    $display("abort test done");
  endtask

  initial begin
    do_reset(RES_SEL_12);
    t_variants();
    t_full();
    t_abort();
    tally_and_finish();
  end
endmodule

`default_nettype wire
